// ### common/encoder_cfg.svh
// Register map, control field positions, reset values.
// Included by the counter core; holds definitions only.
`ifndef ENCODER_CFG_SVH
`define ENCODER_CFG_SVH

// Register word indexes, taken from address bits 4:2
`define CTRL_ADDR 3'h0
`define POS_ADDR 3'h1
`define INIT_ADDR 3'h2
`define GEC_ADDR 3'h3
`define STATUS_ADDR 3'h4

// Control register fields
`define EN_BIT 15
`define SIDL_BIT 13
`define MODE_HI 12
`define MODE_LO 10
`define IMB_BIT 9
`define IMA_BIT 8
`define CTRL_WMASK 16'hBF00
`define CTRL_RESET 16'h0000

// Reset values of the data registers
`define POS_RESET 32'h0000_0000
`define INIT_RESET 32'h0000_0000
`define GEC_RESET 32'hFFFF_FFFF

`endif

// ### common/encoder_link_if.sv
// Bundle between the counter core and the encoder input decoder.
// Pins and match levels flow in, one-cycle event pulses flow out.
`timescale 1ns/10ps
interface encoder_link_if;
  logic phase_a;
  logic phase_b;
  logic index_in;
  logic home_in;
  logic match_a;
  logic match_b;
  logic count_up;
  logic count_down;
  logic index_event;
  logic home_event;

  modport core (
    output phase_a, phase_b, index_in, home_in, match_a, match_b,
    input count_up, count_down, index_event, home_event
  );

  modport decoder (
    input phase_a, phase_b, index_in, home_in, match_a, match_b,
    output count_up, count_down, index_event, home_event
  );
endinterface

// ### common/encoder_pkg.sv
// Types used by the encoder counter core; its input decoder uses none of them.
// Assumes nothing beyond a SystemVerilog compiler.
package encoder_pkg;

  typedef enum logic [2:0] {
    INIT_NONE = 3'h0,
    INIT_EVERY_INDEX = 3'h1,
    INIT_NEXT_INDEX = 3'h2,
    INIT_FIRST_AFTER_HOME = 3'h3,
    INIT_SECOND_AFTER_HOME = 3'h4,
    INIT_GE_RESET = 3'h5,
    INIT_MODULO = 3'h6,
    INIT_RESERVED = 3'h7
  } init_mode_t;

  // Gray coded along wait_home -> wait_index -> wait_second -> done
  typedef enum logic [1:0] {
    ARM_WAIT_HOME = 2'h0,
    ARM_WAIT_INDEX = 2'h1,
    ARM_WAIT_SECOND = 2'h3,
    ARM_DONE = 2'h2
  } arm_state_t;

endpackage

// ### hdl/encoder_counter_init_control.sv
// Quadrature encoder position counter with initialisation control,
// reached over an Avalon-MM slave with waitrequest.
// Assumes encoder pins synchronous to mclk and a 25 MHz clock.
//
// Function
// - Enable bit set runs the position counter and its helpers.
// - Enable bit clear halts counters; registers stay readable and writable.
// - Control bits 14 and 7..0 read zero and ignore writes.
// - Stop-in-idle bit 13 set suspends operation while the cpu idles.
// - Stop-in-idle clear keeps operating while the cpu idles.
// - Mode field bits 12..10 picks init behaviour; 111 is reserved.
// - Mode 110 counts modulo the compare register.
// - Mode 101 clears position when it equals the compare register.
// - Mode 100 loads init value on second index after home.
// - Mode 011 loads init value on first index after home.
// - Mode 010 loads init value on the next index only.
// - Mode 001 clears position on every index event.
// - Mode 000 ignores index events for the position.
// - Phase B match bit gives phase B level needed for index.
// - Phase A match bit 8 gives phase A level needed for index.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "encoder_cfg.svh"
module encoder_counter_init_control
  import encoder_pkg::*;
#(
  parameter int POS_WIDTH = 32,
  parameter int ADDR_WIDTH = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cpu_idle,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic home_input,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [POS_WIDTH-1:0] position,
  output logic counting
);

  encoder_link_if link ();

  logic [15:0] encoder_control;
  logic [POS_WIDTH-1:0] init_value_reg;
  logic [POS_WIDTH-1:0] ge_compare_reg;
  logic [15:0] next_control;
  logic ack;
  logic wr_take;
  logic [2:0] word_sel;
  logic in_range;
  logic running;
  logic load_init;
  logic last_up;
  init_mode_t mode;
  arm_state_t arm_state;
  arm_state_t next_arm_state;
  logic [31:0] read_mux;
  logic [31:0] merged_ctrl;
  logic wr_ctrl;
  logic wr_pos;
  logic wr_init;
  logic wr_gec;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] widen(input logic [POS_WIDTH-1:0] v);
    logic [31:0] res;
    res = 32'h0000_0000;
    res[POS_WIDTH-1:0] = v;
    return res;
  endfunction

  // A taken write that lands on one register word
  function automatic logic word_write(
    input logic take,
    input logic hit,
    input logic [2:0] sel,
    input logic [2:0] target
  );
    return take & hit & (sel == target);
  endfunction

  // Modes whose load waits for a home event first
  function automatic logic needs_home(input init_mode_t m);
    return (m == INIT_FIRST_AFTER_HOME) || (m == INIT_SECOND_AFTER_HOME);
  endfunction

  // ----------------------------------------------------------------
  // Input decoder
  // ----------------------------------------------------------------
  assign link.phase_a = phase_a_input;
  assign link.phase_b = phase_b_input;
  assign link.index_in = index_input;
  assign link.home_in = home_input;
  assign link.match_a = encoder_control[`IMA_BIT];
  assign link.match_b = encoder_control[`IMB_BIT];

  encoder_input_decoder u_decoder (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .link(link)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign word_sel = address[4:2];
  assign in_range = ((address >> 5) == '0);
  assign waitrequest = (read | write) & ~ack;
  assign wr_take = write & ack & clk_en;
  assign wr_ctrl = word_write(wr_take, in_range, word_sel, `CTRL_ADDR);
  assign wr_pos = word_write(wr_take, in_range, word_sel, `POS_ADDR);
  assign wr_init = word_write(wr_take, in_range, word_sel, `INIT_ADDR);
  assign wr_gec = word_write(wr_take, in_range, word_sel, `GEC_ADDR);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= (read | write) & ~ack;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    if (in_range) begin
      unique case (word_sel)
        `CTRL_ADDR: read_mux = {16'h0000, encoder_control};
        `POS_ADDR: read_mux = widen(position);
        `INIT_ADDR: read_mux = widen(init_value_reg);
        `GEC_ADDR: read_mux = widen(ge_compare_reg);
        `STATUS_ADDR: read_mux = {28'h0000000, last_up, running,
          arm_state};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (clk_en && read && !ack) begin
      readdata <= read_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  assign merged_ctrl = merge_bytes({16'h0000, encoder_control}, writedata,
    byteenable);
  assign next_control = merged_ctrl[15:0] & `CTRL_WMASK;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      encoder_control <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      encoder_control <= next_control;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_value_reg <= POS_WIDTH'(`INIT_RESET);
      ge_compare_reg <= POS_WIDTH'(`GEC_RESET);
    end else begin
      if (wr_init) begin
        init_value_reg <= POS_WIDTH'(merge_bytes(widen(init_value_reg),
          writedata, byteenable));
      end
      if (wr_gec) begin
        ge_compare_reg <= POS_WIDTH'(merge_bytes(widen(ge_compare_reg),
          writedata, byteenable));
      end
    end
  end

  assign mode = init_mode_t'(encoder_control[`MODE_HI:`MODE_LO]);
  assign running = encoder_control[`EN_BIT]
    & ~(encoder_control[`SIDL_BIT] & cpu_idle);
  assign counting = running;

  // ----------------------------------------------------------------
  // Index arming sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_arm_state = arm_state;
    load_init = 1'b0;
    unique case (arm_state)
      ARM_WAIT_HOME: begin
        if (link.home_event && needs_home(mode)) begin
          next_arm_state = ARM_WAIT_INDEX;
        end
      end
      ARM_WAIT_INDEX: begin
        if (link.index_event) begin
          if (mode == INIT_SECOND_AFTER_HOME) begin
            next_arm_state = ARM_WAIT_SECOND;
          end else if (mode == INIT_FIRST_AFTER_HOME ||
              mode == INIT_NEXT_INDEX) begin
            load_init = 1'b1;
            next_arm_state = ARM_DONE;
          end
        end
      end
      ARM_WAIT_SECOND: begin
        if (link.index_event && mode == INIT_SECOND_AFTER_HOME) begin
          load_init = 1'b1;
          next_arm_state = ARM_DONE;
        end
      end
      ARM_DONE: begin
        next_arm_state = ARM_DONE;
      end
    endcase
  end

  // A control write restarts arming so a new mode inherits no old state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arm_state <= ARM_WAIT_HOME;
    end else if (wr_ctrl) begin
      if (next_control[`MODE_HI:`MODE_LO] == INIT_NEXT_INDEX) begin
        arm_state <= ARM_WAIT_INDEX;
      end else begin
        arm_state <= ARM_WAIT_HOME;
      end
    end else if (clk_en && running) begin
      arm_state <= next_arm_state;
    end
  end

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  // Software write wins over any hardware update in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      position <= POS_WIDTH'(`POS_RESET);
    end else if (wr_pos) begin
      position <= POS_WIDTH'(merge_bytes(widen(position), writedata,
        byteenable));
    end else if (clk_en && running) begin
      if (load_init) begin
        position <= init_value_reg;
      end else if (mode == INIT_EVERY_INDEX && link.index_event) begin
        position <= '0;
      end else if (mode == INIT_GE_RESET && position == ge_compare_reg) begin
        position <= '0;
      end else if (link.count_up) begin
        if (mode == INIT_MODULO && position == ge_compare_reg) begin
          position <= '0;
        end else begin
          position <= position + 1'b1;
        end
      end else if (link.count_down) begin
        if (mode == INIT_MODULO && position == '0) begin
          position <= ge_compare_reg;
        end else begin
          position <= position - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last_up <= 1'b0;
    end else if (clk_en && running) begin
      if (link.count_up) begin
        last_up <= 1'b1;
      end else if (link.count_down) begin
        last_up <= 1'b0;
      end
    end
  end

endmodule // encoder_counter_init_control

// ### hdl/encoder_input_decoder.sv
// Quadrature step decoder with index and home event detection.
// Pins are synchronous to mclk; events are registered one-cycle pulses.
`timescale 1ns/10ps
module encoder_input_decoder (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  encoder_link_if.decoder link
);

  logic prev_a;
  logic prev_b;
  logic prev_match;
  logic prev_home;
  logic index_match;
  logic step;
  logic dir_up;

  // ----------------------------------------------------------------
  // Index qualification and step direction
  // ----------------------------------------------------------------
  assign index_match = link.index_in & (link.phase_a == link.match_a)
    & (link.phase_b == link.match_b);
  assign step = (link.phase_a ^ prev_a) ^ (link.phase_b ^ prev_b);
  assign dir_up = link.phase_a ^ prev_b;

  // ----------------------------------------------------------------
  // History
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      prev_match <= 1'b0;
      prev_home <= 1'b0;
    end else if (clk_en) begin
      prev_a <= link.phase_a;
      prev_b <= link.phase_b;
      prev_match <= index_match;
      prev_home <= link.home_in;
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.count_up <= 1'b0;
      link.count_down <= 1'b0;
      link.index_event <= 1'b0;
      link.home_event <= 1'b0;
    end else if (clk_en) begin
      link.count_up <= step & dir_up;
      link.count_down <= step & ~dir_up;
      link.index_event <= index_match & ~prev_match;
      link.home_event <= link.home_in & ~prev_home;
    end
  end

endmodule // encoder_input_decoder

// ### test/encoder_counter_init_control_bench.sv
// Self-checking bench for the encoder counter core.
// Assumes the encoder model and a single 25 MHz clock.
`timescale 1ns/10ps
module encoder_counter_init_control_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cpu_idle = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] byteenable = 4'hF;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata, rdata, position;
  logic waitrequest, counting, pa, pb, idx, hom;
  int bad_count = 0;
  int cmp_count = 0;
  always #20 mclk = ~mclk;
  encoder_model encoder_model_inst (
    .mclk(mclk), .phase_a(pa), .phase_b(pb), .index_out(idx), .home_out(hom)
  );
  encoder_counter_init_control encoder_counter_init_control_inst (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .cpu_idle(cpu_idle),
    .phase_a_input(pa), .phase_b_input(pb), .index_input(idx),
    .home_input(hom), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .position(position), .counting(counting)
  );
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task rc(input string s, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(s, rdata, e);
  endtask
  // Enabled control word, match levels taken from the present phases
  task ctl(input logic [2:0] m, input logic [15:0] x);
    bus(1'b1, 5'h00, {16'h0000, {3'h4, m, pb, pa, 8'h00} ^ x});
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_reset;
    rc("ctrl", 5'h00, 32'h00000000);
    rc("init", 5'h08, 32'h00000000);
    rc("gec", 5'h0C, 32'hFFFFFFFF);
    rc("unmapped", 5'h14, 32'h00000000);
    byteenable <= 4'h2;
    bus(1'b1, 5'h08, 32'h12345678);
    byteenable <= 4'hF;
    rc("init bytes", 5'h08, 32'h00005600);
    bus(1'b1, 5'h00, 32'h0000FFFF);
    chk("counting", counting, 1'b1);
    rc("ctrl bits", 5'h00, 32'h0000BF00);
    bus(1'b1, 5'h00, 32'h00000000);
    $display("test reset and bits done");
  endtask
  task t_enable;
    bus(1'b1, 5'h04, 32'h00000000);
    encoder_model_inst.step(1'b1);
    chk("pos off", position, 32'h00000000);
    bus(1'b1, 5'h04, 32'h00000010);
    rc("pos rw off", 5'h04, 32'h00000010);
    ctl(3'h0, 16'h0000);
    repeat (4) encoder_model_inst.step(1'b1);
    chk("pos up", position, 32'h00000014);
    repeat (2) encoder_model_inst.step(1'b0);
    chk("pos down", position, 32'h00000012);
    cpu_idle <= 1'b1;
    ctl(3'h0, 16'h2000);
    encoder_model_inst.step(1'b1);
    chk("pos idle stop", position, 32'h00000012);
    ctl(3'h0, 16'h0000);
    encoder_model_inst.step(1'b1);
    chk("pos idle run", position, 32'h00000013);
    cpu_idle <= 1'b0;
    $display("test enable and idle done");
  endtask
  task t_index;
    ctl(3'h0, 16'h0000);
    encoder_model_inst.pulse(1'b0);
    chk("mode none", position, 32'h00000013);
    ctl(3'h1, 16'h0100);
    encoder_model_inst.pulse(1'b0);
    chk("a mismatch", position, 32'h00000013);
    ctl(3'h1, 16'h0200);
    encoder_model_inst.pulse(1'b0);
    chk("b mismatch", position, 32'h00000013);
    ctl(3'h1, 16'h0000);
    encoder_model_inst.pulse(1'b0);
    chk("every index", position, 32'h00000000);
    bus(1'b1, 5'h08, 32'h00000055);
    ctl(3'h2, 16'h0000);
    encoder_model_inst.pulse(1'b0);
    chk("next load", position, 32'h00000055);
    bus(1'b1, 5'h04, 32'h00000007);
    encoder_model_inst.pulse(1'b0);
    chk("next only", position, 32'h00000007);
    $display("test index modes done");
  endtask
  task t_home;
    ctl(3'h3, 16'h0000);
    encoder_model_inst.pulse(1'b0);
    chk("no home yet", position, 32'h00000007);
    encoder_model_inst.pulse(1'b1);
    encoder_model_inst.pulse(1'b0);
    chk("first after home", position, 32'h00000055);
    ctl(3'h4, 16'h0000);
    bus(1'b1, 5'h04, 32'h00000003);
    encoder_model_inst.pulse(1'b1);
    encoder_model_inst.pulse(1'b0);
    chk("first skipped", position, 32'h00000003);
    encoder_model_inst.pulse(1'b0);
    chk("second after home", position, 32'h00000055);
    $display("test home modes done");
  endtask
  task t_compare;
    bus(1'b1, 5'h0C, 32'h00000020);
    bus(1'b1, 5'h04, 32'h0000001F);
    ctl(3'h5, 16'h0000);
    encoder_model_inst.step(1'b1);
    chk("ge clear", position, 32'h00000000);
    ctl(3'h6, 16'h0000);
    bus(1'b1, 5'h0C, 32'h00000003);
    bus(1'b1, 5'h04, 32'h00000003);
    encoder_model_inst.step(1'b1);
    chk("modulo up", position, 32'h00000000);
    encoder_model_inst.step(1'b0);
    chk("modulo down", position, 32'h00000003);
    $display("test compare modes done");
  endtask
  // Clock enable low freezes the bus and the counter
  task t_freeze;
    clk_en <= 1'b0;
    fork
      bus(1'b1, 5'h04, 32'h00000009);
      begin
        repeat (4) @(posedge mclk);
        chk("frozen wait", waitrequest, 1'b1);
        chk("frozen pos", position, 32'h00000003);
        clk_en <= 1'b1;
      end
    join
    rc("pos after freeze", 5'h04, 32'h00000009);
    $display("test clock enable done");
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_enable;
    t_index;
    t_home;
    t_compare;
    t_freeze;
    final_report;
  end
  initial begin
    #400000;
    bad_count++;
    final_report;
  end
endmodule // encoder_counter_init_control_bench

// ### test/encoder_model.sv
// Ideal quadrature encoder with index and home outputs.
// Assumes the caller enters its tasks right after a rising edge.
`timescale 1ns/10ps
module encoder_model (
  input wire logic mclk,
  output logic phase_a,
  output logic phase_b,
  output logic index_out,
  output logic home_out
);
  logic [1:0] q = 2'h0;
  initial begin
    index_out = 1'b0;
    home_out = 1'b0;
  end
  // Gray walk 00,10,11,01: phase A leads when turning up
  assign phase_a = q[0] ^ q[1];
  assign phase_b = q[1];
  task step(input logic up);
    @(posedge mclk);
    q <= up ? q + 2'h1 : q - 2'h1;
    repeat (4) @(posedge mclk);
  endtask
  task pulse(input logic home);
    @(posedge mclk);
    if (home) index_out <= 1'b0;
    else index_out <= 1'b1;
    home_out <= home;
    repeat (3) @(posedge mclk);
    index_out <= 1'b0;
    home_out <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule // encoder_model

// ### test/encoder_monitor.sv
// Checker for the encoder counter core, bound to its top ports.
// Assumes full-word writes to the control and compare words.
`timescale 1ns/10ps
module encoder_monitor #(
  parameter int POS_WIDTH = 32,
  parameter int ADDR_WIDTH = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cpu_idle,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [POS_WIDTH-1:0] position,
  input wire logic counting
);
  // ------------------------------
  // Shadow of software settings
  // ------------------------------
  logic [15:0] ctrl_s;
  logic [31:0] gec_s;
  logic [2:0] mode;
  logic hit, wr_ok;
  assign wr_ok = write && !waitrequest && clk_en;
  assign mode = ctrl_s[12:10];
  assign hit = index_input && phase_a_input == ctrl_s[8]
    && phase_b_input == ctrl_s[9];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_s <= 16'h0000;
      gec_s <= 32'hFFFFFFFF;
    end else if (wr_ok && address[4:2] == 3'h0) begin
      ctrl_s <= writedata[15:0] & 16'hBF00;
    end else if (wr_ok && address[4:2] == 3'h3) begin
      gec_s <= writedata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence req_start;
    $rose(read || write) && clk_en;
  endsequence
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence quiet;
    $stable(phase_a_input) && $stable(phase_b_input) && !wr_ok;
  endsequence
  a_bus_one_wait: assert property (req_start |-> one_wait)
    else $error("bus answer not after one wait cycle");
  a_count_gate: assert property (
    counting == (ctrl_s[15] && !(ctrl_s[13] && cpu_idle)))
    else $error("counting does not follow enable and idle");
  a_halt_holds: assert property (
    !counting && !wr_ok |=> $stable(position))
    else $error("position moved while halted");
  a_step_moves: assert property (
    counting && mode == 3'h0 &&
    ($changed(phase_a_input) != $changed(phase_b_input))
    |-> ##[1:2] $changed(position))
    else $error("step did not move position");
  a_ctrl_readback: assert property (
    read && !waitrequest && address[4:2] == 3'h0
    |-> readdata[15:0] == ctrl_s)
    else $error("control read back wrong");
  a_index_clear: assert property (
    counting && mode == 3'h1 && $rose(hit) |-> ##[1:3] position == '0)
    else $error("index did not clear position");
  a_ge_clear: assert property (
    counting && mode == 3'h5 && position == gec_s && !wr_ok
    |-> ##[1:2] position == '0)
    else $error("equal compare did not clear position");
  a_index_ignored: assert property (
    quiet[*3] ##0 (counting && mode == 3'h0 && $rose(hit)) ##1 quiet[*3]
    |-> position == $past(position, 3))
    else $error("index moved position in mode none");
endmodule // encoder_monitor

bind encoder_counter_init_control encoder_monitor #(
  .POS_WIDTH(POS_WIDTH),
  .ADDR_WIDTH(ADDR_WIDTH)
) encoder_monitor_inst (
  .mclk(mclk), .rst(rst), .clk_en(clk_en), .cpu_idle(cpu_idle),
  .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
  .index_input(index_input), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .position(position), .counting(counting)
);
